/* File: dv/cag_addr_gen_chk.sv */
// Port assertions for the address generation block
`timescale 1ns/100ps

module cag_addr_gen_chk
	import cag_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic br_valid_i,
	input wire cag_br_mode_t br_mode_i,
	input wire logic br_is_branch_i,
	input wire logic [19:0] next_pc_i,
	input wire logic [15:0] disp_i,
	input wire logic [19:0] imm_target_i,
	input wire logic [4:0] tbl_idx_i,
	input wire logic tbl_rd_o,
	input wire logic [19:0] tbl_addr_o,
	input wire logic pc_load_o,
	input wire logic [19:0] program_counter_o,
	input wire logic br_busy_o,
	input wire logic br_illegal_o,
	input wire logic dm_valid_i,
	input wire cag_dm_mode_t dm_mode_i,
	input wire logic bank_prefix_i,
	input wire logic [1:0] pair_sel_i,
	input wire logic [7:0] imm8_i,
	input wire logic [15:0] imm16_i,
	input wire logic [3:0] data_bank_register_i,
	input wire logic [63:0] reg_bank_i,
	input wire logic dm_done_o,
	input wire logic [19:0] dm_addr_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// ****************************************
	// Accepted requests
	// ****************************************
	// A branch is only taken while no table fetch runs
	sequence s_br(cag_br_mode_t m);
		br_valid_i && !br_busy_o && br_mode_i == m;
	endsequence
	sequence s_dm(cag_dm_mode_t m);
		dm_valid_i && dm_mode_i == m;
	endsequence
	// ****************************************
	// Branch targets
	// ****************************************
	a_rel_short_sum: assert property (s_br(BR_REL8) ##0 br_is_branch_i |=> pc_load_o &&
		program_counter_o == $past(next_pc_i) + {{12{$past(disp_i[7])}}, $past(disp_i[7:0])})
		else $error("relative target wrong");
	a_rel_non_branch: assert property (s_br(BR_REL16) ##0 !br_is_branch_i |=>
		br_illegal_o && !pc_load_o) else $error("relative form accepted off a branch");
	a_imm_full_copy: assert property (s_br(BR_IMM20) |=>
		pc_load_o && program_counter_o == $past(imm_target_i)) else $error("wide target wrong");
	a_imm_upper_zero: assert property (s_br(BR_IMM16) |=>
		program_counter_o == {4'h0, $past(imm_target_i[15:0])}) else $error("short target wrong");
	a_table_entry_addr: assert property (s_br(BR_TABLE) |=> tbl_rd_o &&
		tbl_addr_o == {4'h0, 16'h0080 + {10'h0, $past(tbl_idx_i), 1'b0}})
		else $error("table entry address wrong");
	a_table_low_bank: assert property (pc_load_o && $past(tbl_rd_o) |->
		program_counter_o[19:16] == 4'h0) else $error("table target left low bank");
	// ****************************************
	// Data operand addresses
	// ****************************************
	a_direct_top_bank: assert property (s_dm(DM_DIRECT) ##0 !bank_prefix_i |=>
		dm_done_o && dm_addr_o == {4'hf, $past(imm16_i)}) else $error("direct address wrong");
	a_direct_data_bank: assert property (s_dm(DM_DIRECT) ##0 bank_prefix_i |=>
		dm_addr_o == {$past(data_bank_register_i), $past(imm16_i)})
		else $error("banked direct address wrong");
	a_short_window_map: assert property (s_dm(DM_SHORT) |=> dm_done_o &&
		dm_addr_o == {(($past(imm8_i) < 8'h20) ? 12'hfff : 12'hffe), $past(imm8_i)})
		else $error("short address wrong");
	a_indirect_top_bank: assert property (s_dm(DM_INDIRECT) ##0 !bank_prefix_i &&
		pair_sel_i[1] |=> dm_addr_o == {4'hf, $past(reg_bank_i[{pair_sel_i, 4'h0} +: 16])})
		else $error("indirect address wrong");
endmodule

bind cag_addr_gen cag_addr_gen_chk u_chk (.*);

/* File: dv/cag_addr_gen_tb_top.sv */
// Self-checking bench for the address generation block
`timescale 1ns/100ps

module cag_addr_gen_tb_top;
	import cag_pkg::*;
	localparam logic [25:0] ILL = 26'h2000000; // Refused form
	logic clk_i = 1'b0, rst_b_i = 1'b0, slow = 1'b0;
	logic br_valid_i = 1'b0, br_is_branch_i = 1'b0, br_is_call_i = 1'b0;
	cag_br_mode_t br_mode_i = BR_NONE;
	logic [19:0] next_pc_i = 20'h0, imm_target_i = 20'h0, tbl_addr_o, program_counter_o, dm_addr_o;
	logic [15:0] disp_i = 16'h0, imm16_i = 16'h0, stack_pointer_i = 16'h0;
	logic [4:0] tbl_idx_i = 5'h0;
	logic [1:0] br_pair_sel_i = 2'h0, pair_sel_i = 2'h0;
	logic [3:0] code_bank_register_i = 4'h0, data_bank_register_i = 4'h0;
	logic tbl_rd_o, tbl_rd_ack_i, pc_load_o, br_busy_o, br_illegal_o;
	logic [7:0] tbl_rd_data_i, imm8_i = 8'h0;
	logic dm_valid_i = 1'b0, bank_prefix_i = 1'b0, is_unsigned_multiply_i = 1'b0;
	logic use_stack_pointer_i = 1'b0, dm_done_o, dm_is_reg_o, dm_reg_word_o, dm_illegal_o;
	cag_dm_mode_t dm_mode_i = DM_NONE;
	logic [2:0] reg_sel_i = 3'h0, dm_reg_idx_o;
	logic [63:0] reg_bank_i = 64'h0;
	logic [25:0] bq[$], dq[$]; // Expected branch and data results
	logic [15:0] lf = 16'h0041; // Random source state
	int fails = 0, num_checks = 0;

	cag_addr_gen DUT (.*);
	cag_tbl_mem u_mem (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow), .rd_i(tbl_rd_o),
		.addr_i(tbl_addr_o), .ack_o(tbl_rd_ack_i), .data_o(tbl_rd_data_i));

	always #12.5 clk_i = ~clk_i;

	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction

	task automatic cmp(input logic [25:0] e, input logic [25:0] g);
		num_checks++;
		if (e !== g) begin
			fails++;
			$display("unexpected at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	// ****************************************
	// Result watcher
	// ****************************************
	// Sampled mid-cycle so registered pulses have settled
	always @(negedge clk_i) begin
		if (rst_b_i && (pc_load_o || br_illegal_o))
			cmp(bq.size() ? bq.pop_front() : 26'hx,
				{br_illegal_o, 5'h0, br_illegal_o ? 20'h0 : program_counter_o});
		if (rst_b_i && (dm_done_o || dm_illegal_o))
			cmp(dq.size() ? dq.pop_front() : 26'hx, {dm_illegal_o, dm_is_reg_o, dm_reg_word_o,
				dm_reg_idx_o, (dm_is_reg_o || dm_illegal_o) ? 20'h0 : dm_addr_o});
	end

	// Branch request; waits for the answer so none is sent while busy
	task automatic br_req(input cag_br_mode_t md, input logic isb, input logic isc,
		input logic [1:0] ps, input logic [4:0] ix, input logic [15:0] d);
		logic [19:0] np, im;
		logic [3:0] cb;
		logic [63:0] rb;
		logic [15:0] a;
		logic [25:0] e;
		np = 20'({rnd(), rnd()});
		im = 20'({rnd(), rnd()});
		cb = 4'(rnd());
		rb = {rnd(), rnd(), rnd(), rnd()};
		a = 16'h0080 + {10'h0, ix, 1'b0};
		case (md)
			BR_REL8: e = isb ? {6'h0, np + {{12{d[7]}}, d[7:0]}} : ILL;
			BR_REL16: e = isb ? {6'h0, np + {{4{d[15]}}, d}} : ILL;
			BR_IMM20: e = {6'h0, im};
			BR_IMM16: e = {10'h0, im[15:0]};
			BR_TABLE: e = {10'h0, a[7:0] ^ 8'h5b, a[7:0] ^ 8'h5a};
			BR_REG: e = (isc || ps == PAIR_0) ? {6'h0, cb, rb[{ps, 4'h0} +: 16]} : ILL;
			default: e = ILL;
		endcase
		bq.push_back(e);
		@(posedge clk_i);
		br_valid_i <= 1'b1;
		br_mode_i <= md;
		br_is_branch_i <= isb;
		br_is_call_i <= isc;
		br_pair_sel_i <= ps;
		tbl_idx_i <= ix;
		disp_i <= d;
		next_pc_i <= np;
		imm_target_i <= im;
		code_bank_register_i <= cb;
		reg_bank_i <= rb;
		@(posedge clk_i);
		br_valid_i <= 1'b0;
		// Answers are looked at mid-cycle, clear of the edge that launches them
		for (int k = 0; k < 30; k++) begin
			@(negedge clk_i);
			// Only a table call keeps the sequencer busy after it is taken
			if (k == 0) cmp({25'h0, md == BR_TABLE}, {25'h0, br_busy_o});
			if (pc_load_o || br_illegal_o) break;
		end
	endtask

	// Operand request, one per cycle; u selects multiply or stack pointer
	task automatic dm_req(input cag_dm_mode_t md, input logic pre, input logic u,
		input logic [2:0] rs, input logic [1:0] ps, input logic [7:0] i8);
		logic [15:0] i16, sp, p, b;
		logic [3:0] db, hi;
		logic [63:0] rb;
		logic [25:0] e;
		i16 = rnd();
		sp = rnd();
		db = 4'(rnd());
		rb = {rnd(), rnd(), rnd(), rnd()};
		p = rb[{ps, 4'h0} +: 16];
		b = {8'h0, rb[{rs, 3'h0} +: 8]};
		hi = pre ? db : 4'hf;
		case (md)
			DM_IMPLIED: e = u ? 26'h1000000 : ILL;
			DM_REG8: e = {3'h2, rs, 20'h0};
			DM_REG16: e = {3'h3, ps, 1'b0, 20'h0};
			DM_DIRECT: e = {6'h0, hi, i16};
			DM_SHORT, DM_SHORT_PAIR: e = (md == DM_SHORT_PAIR && i8[0]) ? ILL :
				{6'h0, ((i8 < 8'h20) ? 12'hfff : 12'hffe), i8};
			DM_SPECIAL, DM_SPECIAL_PAIR: e = (md == DM_SPECIAL_PAIR && i8[0]) ? ILL :
				{6'h0, 12'hfff, i8};
			DM_INDIRECT: e = ps[1] ? {6'h0, hi, p} : ILL;
			DM_BASED: e = u ? {10'h00f, sp + {8'h0, i8}} : ps[1] ? {6'h0, hi, p + {8'h0, i8}} : ILL;
			DM_WORD_IDX: e = (rs[2:1] == 2'h1) ? {6'h0, hi, i16 + b} : ILL;
			DM_PAIR_IDX: e = {6'h0, hi, i16 + rb[31:16]};
			default: e = ILL;
		endcase
		dq.push_back(e);
		@(posedge clk_i);
		dm_valid_i <= 1'b1;
		dm_mode_i <= md;
		bank_prefix_i <= pre;
		is_unsigned_multiply_i <= u;
		use_stack_pointer_i <= u;
		reg_sel_i <= rs;
		pair_sel_i <= ps;
		imm8_i <= i8;
		imm16_i <= i16;
		data_bank_register_i <= db;
		stack_pointer_i <= sp;
		reg_bank_i <= rb;
	endtask

	task tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog sized well past the whole sequence
	initial begin
		#(25 * 4000);
		fails++;
		tally_and_finish;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (5) @(posedge clk_i);
		rst_b_i <= 1'b1;
		br_req(BR_REL8, 1, 0, 0, 0, 16'h0080);
		br_req(BR_REL8, 1, 0, 0, 0, 16'hff7f);
		br_req(BR_REL16, 1, 0, 0, 0, 16'h8000);
		br_req(BR_REL8, 0, 0, 0, 0, 16'h0001);
		br_req(BR_REL16, 0, 0, 0, 0, 16'h0001);
		br_req(BR_IMM20, 1, 1, 0, 0, 0);
		br_req(BR_IMM16, 1, 0, 0, 0, 0);
		br_req(BR_NONE, 1, 0, 0, 0, 0);
		// Prompt and slow table memory, first and last entry
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			br_req(BR_TABLE, 1, 1, 0, 5'h00, 0);
			br_req(BR_TABLE, 1, 1, 0, 5'h1f, 0);
		end
		for (int p = 0; p < 4; p++) begin
			br_req(BR_REG, 1, 1, p[1:0], 0, 0);
			br_req(BR_REG, 1, 0, p[1:0], 0, 0);
		end
		// Data requests run back to back
		dm_req(DM_IMPLIED, 0, 1, 0, 0, 0);
		dm_req(DM_IMPLIED, 0, 0, 0, 0, 0);
		for (int r = 0; r < 8; r++) dm_req(DM_REG8, 0, 0, r[2:0], 0, 0);
		for (int r = 0; r < 4; r++) begin
			dm_req(DM_REG16, 0, 0, 0, r[1:0], 0);
			dm_req(DM_INDIRECT, 0, 0, 0, r[1:0], 0);
			dm_req(DM_INDIRECT, 1, 0, 0, r[1:0], 0);
			dm_req(DM_BASED, r[0], 0, 0, r[1:0], 8'hff);
			dm_req(DM_WORD_IDX, r[0], 0, r[2:0], 0, 8'h00);
			dm_req(DM_SHORT, 0, 0, 0, 0, 8'(32'h001f20ff >> (r * 8)));
		end
		dm_req(DM_BASED, 1, 1, 0, 0, 8'h80);
		dm_req(DM_DIRECT, 0, 0, 0, 0, 0);
		dm_req(DM_DIRECT, 1, 0, 0, 0, 0);
		dm_req(DM_SHORT_PAIR, 0, 0, 0, 0, 8'h20);
		dm_req(DM_SHORT_PAIR, 0, 0, 0, 0, 8'h21);
		dm_req(DM_SPECIAL, 0, 0, 0, 0, 8'(rnd()));
		dm_req(DM_SPECIAL_PAIR, 0, 0, 0, 0, 8'h03);
		dm_req(DM_PAIR_IDX, 0, 0, 0, 0, 0);
		dm_req(DM_PAIR_IDX, 1, 0, 0, 0, 0);
		dm_req(DM_NONE, 0, 0, 0, 0, 0);
		@(posedge clk_i);
		dm_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		// Every expected result must have appeared
		cmp(26'h0, 26'(bq.size() + dq.size()));
		tally_and_finish;
	end
endmodule

/* File: dv/cag_tbl_mem.sv */
// Behavioural call table memory answering table byte reads
`timescale 1ns/100ps

module cag_tbl_mem (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic slow_i, // Wait three cycles before each answer
	input wire logic rd_i, // Table read strobe
	input wire logic [19:0] addr_i, // Table byte address
	output logic ack_o, // Byte valid pulse
	output logic [7:0] data_o // Byte, scrambled outside the ack cycle
);
	logic [1:0] wait_r; // Cycles spent on the current byte
	// One ack per byte; the data line never keeps a stale byte
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			wait_r <= 2'h0;
			ack_o <= 1'b0;
			data_o <= 8'h00;
		end else if (rd_i && !ack_o && (!slow_i || wait_r == 2'h3)) begin
			wait_r <= 2'h0;
			ack_o <= 1'b1;
			data_o <= addr_i[7:0] ^ 8'h5a;
		end else begin
			wait_r <= rd_i ? wait_r + 2'h1 : 2'h0;
			ack_o <= 1'b0;
			data_o <= ~data_o;
		end
	end
endmodule

/* File: verilog/cag_addr_gen.sv */
// Address generation for branch targets and data operands
`timescale 1ns/100ps

module cag_addr_gen
	import cag_pkg::*;
(
	input wire logic clk_i, // Core clock, 40 MHz
	input wire logic rst_b_i, // Synchronous reset, active low
	// Branch request from the decoder
	input wire logic br_valid_i, // One-cycle branch request
	input wire cag_br_mode_t br_mode_i, // Branch target mode
	input wire logic br_is_branch_i, // Instruction is a branch or call
	input wire logic br_is_call_i, // Instruction is a call
	input wire logic [19:0] next_pc_i, // Address of next instruction
	input wire logic [15:0] disp_i, // Displacement, low byte for 8-bit form
	input wire logic [19:0] imm_target_i, // Immediate target field
	input wire logic [4:0] tbl_idx_i, // Table call selector
	input wire logic [1:0] br_pair_sel_i, // Pair for register branch
	input wire logic [3:0] code_bank_register_i, // Code bank
	// Table fetch over the memory bus
	output logic tbl_rd_o, // Table byte read strobe
	output logic [19:0] tbl_addr_o, // Table byte address
	input wire logic tbl_rd_ack_i, // Read data valid
	input wire logic [7:0] tbl_rd_data_i, // Table byte
	// Branch answer
	output logic pc_load_o, // Program counter load pulse
	output logic [19:0] program_counter_o, // New target
	output logic br_busy_o, // Table fetch in progress
	output logic br_illegal_o, // Refused branch form
	// Data operand request
	input wire logic dm_valid_i, // One-cycle operand request
	input wire cag_dm_mode_t dm_mode_i, // Operand mode
	input wire logic bank_prefix_i, // Bank prefix present
	input wire logic is_unsigned_multiply_i, // Opcode is unsigned multiply
	input wire logic [2:0] reg_sel_i, // Byte register field
	input wire logic [1:0] pair_sel_i, // Pair field
	input wire logic use_stack_pointer_i, // Based form uses stack pointer
	input wire logic [15:0] imm16_i, // Immediate address or base
	input wire logic [7:0] imm8_i, // Short or offset byte
	input wire logic [3:0] data_bank_register_i, // Data bank
	input wire logic [15:0] stack_pointer_i, // Stack pointer
	input wire logic [63:0] reg_bank_i, // Current bank, byte i at [8i+7:8i]
	// Data answer
	output logic dm_done_o, // Operand address or register valid pulse
	output logic [19:0] dm_addr_o, // Memory address
	output logic dm_is_reg_o, // Operand is a register
	output logic [2:0] dm_reg_idx_o, // Byte register index
	output logic dm_reg_word_o, // Register operand is a pair
	output logic dm_illegal_o // Refused operand form
);

	// ****************************************
	// Helper functions
	// ****************************************
	// Byte register read, codes in listed order
	function automatic logic [7:0] byte_reg(input logic [63:0] bank, input logic [2:0] sel);
		byte_reg = bank[{sel, 3'h0} +: 8];
	endfunction

	// Pair read, pair n is byte registers 2n and 2n+1
	function automatic logic [15:0] pair_reg(input logic [63:0] bank, input logic [1:0] sel);
		pair_reg = bank[{sel, 4'h0} +: 16];
	endfunction

	// Upper bits: data bank when prefixed, otherwise top bank
	function automatic logic [3:0] upper(input logic pfx, input logic [3:0] bank);
		upper = pfx ? bank : BANK_TOP;
	endfunction

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		cag_tbl_state_t tst; // Table fetch state
		logic [7:0] tbl_lo; // First table byte
		logic [15:0] tbl_ptr; // Table entry address
		logic pc_load; // Load pulse
		logic [19:0] pc; // Target
		logic br_ill; // Refused branch
		logic dm_done; // Operand pulse
		logic [19:0] dm_addr; // Operand address
		logic dm_is_reg; // Register operand
		logic [2:0] dm_reg_idx; // Register index
		logic dm_reg_word; // Pair operand
		logic dm_ill; // Refused operand
	} cag_state_t;

	cag_state_t st_r; // Registered state
	cag_state_t st_nxt; // Next state

	logic [15:0] disp_ext; // Sign-extended displacement
	logic [15:0] base_sum; // Sixteen-bit sum for based forms
	logic [15:0] base_val; // Base operand
	logic [15:0] offs_val; // Offset operand

	// ****************************************
	// Next-state logic
	// ****************************************
	// All decoding is combinational; results are registered one cycle later
	always_comb begin
		st_nxt = st_r;
		st_nxt.pc_load = 1'b0;
		st_nxt.br_ill = 1'b0;
		st_nxt.dm_done = 1'b0;
		st_nxt.dm_ill = 1'b0;

		// Displacement width follows the branch mode
		if (br_mode_i == BR_REL8) begin
			disp_ext = {{8{disp_i[7]}}, disp_i[7:0]};
		end else begin
			disp_ext = disp_i;
		end

		// Table fetch sequencer
		case (st_r.tst)
			TS_IDLE: begin
				// Branch requests are ignored while a table fetch runs
				if (br_valid_i) begin
					case (br_mode_i)
						BR_REL8, BR_REL16: begin
							if (br_is_branch_i) begin
								st_nxt.pc = next_pc_i + {{4{disp_ext[15]}}, disp_ext};
								st_nxt.pc_load = 1'b1;
							end else begin
								st_nxt.br_ill = 1'b1;
							end
						end
						BR_IMM20: begin
							st_nxt.pc = imm_target_i;
							st_nxt.pc_load = 1'b1;
						end
						BR_IMM16: begin
							st_nxt.pc = {BANK_ZERO, imm_target_i[15:0]};
							st_nxt.pc_load = 1'b1;
						end
						BR_TABLE: begin
							// Each entry is two bytes wide
							st_nxt.tbl_ptr = TABLE_BASE + {10'h000, tbl_idx_i, 1'b0};
							st_nxt.tst = TS_LOW;
						end
						BR_REG: begin
							// Calls may use any pair, plain branches only pair 0
							if (br_is_call_i || br_pair_sel_i == PAIR_0) begin
								st_nxt.pc = {code_bank_register_i,
									pair_reg(reg_bank_i, br_pair_sel_i)};
								st_nxt.pc_load = 1'b1;
							end else begin
								st_nxt.br_ill = 1'b1;
							end
						end
						default: begin
							st_nxt.br_ill = 1'b1;
						end
					endcase
				end
			end
			TS_LOW: begin
				// Wait for the low target byte
				if (tbl_rd_ack_i) begin
					st_nxt.tbl_lo = tbl_rd_data_i;
					st_nxt.tbl_ptr = st_r.tbl_ptr + 16'h0001;
					st_nxt.tst = TS_HIGH;
				end
			end
			TS_HIGH: begin
				// High byte completes the target in the lowest bank
				if (tbl_rd_ack_i) begin
					st_nxt.pc = {BANK_ZERO, tbl_rd_data_i, st_r.tbl_lo};
					st_nxt.pc_load = 1'b1;
					st_nxt.tst = TS_IDLE;
				end
			end
			default: begin
				st_nxt.tst = TS_IDLE;
			end
		endcase

		// Based and indexed operands
		case (dm_mode_i)
			DM_BASED: begin
				base_val = use_stack_pointer_i ? stack_pointer_i
					: pair_reg(reg_bank_i, pair_sel_i);
				offs_val = {8'h00, imm8_i};
			end
			DM_WORD_IDX: begin
				base_val = imm16_i;
				offs_val = {8'h00, byte_reg(reg_bank_i, reg_sel_i)};
			end
			default: begin
				base_val = imm16_i;
				offs_val = pair_reg(reg_bank_i, PAIR_1);
			end
		endcase
		// Carry out of bit 15 is dropped so the bank never changes
		base_sum = base_val + offs_val;

		// Data operand decode
		if (dm_valid_i) begin
			st_nxt.dm_done = 1'b1;
			st_nxt.dm_is_reg = 1'b0;
			st_nxt.dm_reg_word = 1'b0;
			st_nxt.dm_reg_idx = 3'h0;
			st_nxt.dm_addr = 20'h00000;
			case (dm_mode_i)
				DM_IMPLIED: begin
					// Implied operand names the X byte register
					if (is_unsigned_multiply_i) begin
						st_nxt.dm_is_reg = 1'b1;
					end else begin
						st_nxt.dm_ill = 1'b1;
					end
				end
				DM_REG8: begin
					st_nxt.dm_is_reg = 1'b1;
					st_nxt.dm_reg_idx = reg_sel_i;
				end
				DM_REG16: begin
					st_nxt.dm_is_reg = 1'b1;
					st_nxt.dm_reg_word = 1'b1;
					st_nxt.dm_reg_idx = {pair_sel_i, 1'b0};
				end
				DM_DIRECT: begin
					st_nxt.dm_addr = {upper(bank_prefix_i, data_bank_register_i), imm16_i};
				end
				DM_SHORT, DM_SHORT_PAIR: begin
					// Reserved sub-ranges are the program's concern, not checked here
					if (imm8_i >= SHORT_SPLIT) begin
						st_nxt.dm_addr = SHORT_LO_BASE | {12'h000, imm8_i};
					end else begin
						st_nxt.dm_addr = SHORT_HI_BASE | {12'h000, imm8_i};
					end
					if (dm_mode_i == DM_SHORT_PAIR && imm8_i[0]) begin
						st_nxt.dm_ill = 1'b1;
					end
				end
				DM_SPECIAL, DM_SPECIAL_PAIR: begin
					st_nxt.dm_addr = SPECIAL_BASE | {12'h000, imm8_i};
					if (dm_mode_i == DM_SPECIAL_PAIR && imm8_i[0]) begin
						st_nxt.dm_ill = 1'b1;
					end
				end
				DM_INDIRECT: begin
					// Only pairs 2 and 3 may point to memory
					if (pair_sel_i == PAIR_2 || pair_sel_i == PAIR_3) begin
						st_nxt.dm_addr = {upper(bank_prefix_i, data_bank_register_i),
							pair_reg(reg_bank_i, pair_sel_i)};
					end else begin
						st_nxt.dm_ill = 1'b1;
					end
				end
				DM_BASED: begin
					// Stack form has no prefixed variant; pairs 2 and 3 otherwise
					if (use_stack_pointer_i || pair_sel_i == PAIR_2
						|| pair_sel_i == PAIR_3) begin
						st_nxt.dm_addr = {upper(bank_prefix_i && !use_stack_pointer_i,
							data_bank_register_i), base_sum};
					end else begin
						st_nxt.dm_ill = 1'b1;
					end
				end
				DM_WORD_IDX: begin
					// Offset register is byte register 2 or 3
					if (reg_sel_i == 3'h2 || reg_sel_i == 3'h3) begin
						st_nxt.dm_addr = {upper(bank_prefix_i, data_bank_register_i),
							base_sum};
					end else begin
						st_nxt.dm_ill = 1'b1;
					end
				end
				DM_PAIR_IDX: begin
					st_nxt.dm_addr = {upper(bank_prefix_i, data_bank_register_i),
						base_sum};
				end
				default: begin
					st_nxt.dm_ill = 1'b1;
				end
			endcase
			// A refused request yields no valid address
			if (st_nxt.dm_ill) begin
				st_nxt.dm_done = 1'b0;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign tbl_rd_o = (st_r.tst != TS_IDLE); // Held until acknowledged
	assign tbl_addr_o = {BANK_ZERO, st_r.tbl_ptr};
	assign br_busy_o = (st_r.tst != TS_IDLE);
	assign pc_load_o = st_r.pc_load;
	assign program_counter_o = st_r.pc;
	assign br_illegal_o = st_r.br_ill;
	assign dm_done_o = st_r.dm_done;
	assign dm_addr_o = st_r.dm_addr;
	assign dm_is_reg_o = st_r.dm_is_reg;
	assign dm_reg_idx_o = st_r.dm_reg_idx;
	assign dm_reg_word_o = st_r.dm_reg_word;
	assign dm_illegal_o = st_r.dm_ill;

endmodule

/* File: verilog/cag_pkg.sv */
// Package of constants and types for the cpu address generation block
package cag_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 20; // Full address width
	localparam int LOW_W = 16; // Bank-relative address width
	localparam int BANK_W = 4; // Upper address bits
	localparam int TBL_IDX_W = 5; // Table call selector width

	// ****************************************
	// Fixed upper bits and windows
	// ****************************************
	localparam logic [3:0] BANK_TOP = 4'hf; // Top 64 KB bank
	localparam logic [3:0] BANK_ZERO = 4'h0; // Lowest 64 KB bank
	localparam logic [19:0] SHORT_LO_BASE = 20'hffe00; // Operand 20h..FFh
	localparam logic [19:0] SHORT_HI_BASE = 20'hfff00; // Operand 00h..1Fh
	localparam logic [7:0] SHORT_SPLIT = 8'h20; // First operand of lower part
	localparam logic [19:0] SPECIAL_BASE = 20'hfff00; // Special register window
	localparam logic [15:0] TABLE_BASE = 16'h0080; // Call table start

	// ****************************************
	// Selector codes
	// ****************************************
	localparam logic [1:0] PAIR_0 = 2'h0; // Accumulator pair
	localparam logic [1:0] PAIR_1 = 2'h1;
	localparam logic [1:0] PAIR_2 = 2'h2;
	localparam logic [1:0] PAIR_3 = 2'h3;

	// Branch target modes
	typedef enum logic [2:0] {
		BR_NONE,
		BR_REL8,
		BR_REL16,
		BR_IMM20,
		BR_IMM16,
		BR_TABLE,
		BR_REG
	} cag_br_mode_t;

	// Data operand modes
	typedef enum logic [3:0] {
		DM_NONE,
		DM_IMPLIED,
		DM_REG8,
		DM_REG16,
		DM_DIRECT,
		DM_SHORT,
		DM_SHORT_PAIR,
		DM_SPECIAL,
		DM_SPECIAL_PAIR,
		DM_INDIRECT,
		DM_BASED,
		DM_WORD_IDX,
		DM_PAIR_IDX
	} cag_dm_mode_t;

	// Table call sequencer states
	typedef enum logic [1:0] {
		TS_IDLE,
		TS_LOW,
		TS_HIGH
	} cag_tbl_state_t;

endpackage
